// >>> sfer_pkg.sv
// Package of codes, states and timing constants for the serial link fatal error reporter
package sfer_pkg;
  // Minor error codes
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_INACT = 8'h20;
  localparam logic [7:0] CODE_PARITY = 8'h21;
  localparam logic [7:0] CODE_BCC = 8'h22;
  localparam logic [7:0] CODE_FRAME = 8'h23;
  localparam logic [7:0] CODE_BAD_TYPE = 8'h24;
  localparam logic [7:0] CODE_ATT_LEN = 8'h25;
  localparam logic [7:0] CODE_UNEXP_TYPE = 8'h26;
  localparam logic [7:0] CODE_BREAK2 = 8'h27;
  localparam logic [7:0] CODE_TX_RETRY = 8'h28;
  localparam logic [7:0] CODE_RX_NAK = 8'h29;
  localparam logic [7:0] CODE_NOT_ACK = 8'h2A;
  localparam logic [7:0] CODE_SEQ = 8'h2B;
  localparam logic [7:0] CODE_LEN = 8'h2C;
  localparam logic [7:0] CODE_ACK_TO = 8'h2D;
  localparam logic [7:0] CODE_RESP_TO = 8'h2E;
  localparam logic [7:0] CODE_BUF_TO = 8'h2F;
  localparam logic [7:0] CODE_TX_TO = 8'h30;
  localparam logic [7:0] CODE_SRP = 8'h31;
  localparam logic [7:0] CODE_REQ_TO = 8'h32;
  localparam logic [7:0] CODE_BREAK = 8'h33;
  localparam logic [7:0] CODE_PIGGY = 8'h35;
  localparam logic [7:0] CODE_ID = 8'h36;
  localparam logic [7:0] CODE_DLEN = 8'h37;
  localparam logic [7:0] CODE_RCODE = 8'h38;
  localparam logic [7:0] CODE_BIG = 8'h39;
  // Fatal range bounds
  localparam logic [7:0] FATAL_LO = 8'h20;
  localparam logic [7:0] FATAL_HI = 8'h76;
  // Retry and size limits
  localparam logic [1:0] MAX_RETRY = 2'h2;
  localparam logic [15:0] MAX_FAST_DATA = 16'h03E8;
  localparam logic [7:0] RESP_OFFSET = 8'h80;
  // Identifier length in bytes
  localparam int ID_BYTES = 8;
  // Timer unit: a one-millisecond tick from the 50 MHz clock
  localparam int CLK_HZ = 50000000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
  localparam int TIMER_W = 16;
  // Protocol phase, one-hot
  typedef enum logic [5:0] {
    SFER_IDLE = 6'h01,
    SFER_ATTACH = 6'h02,
    SFER_SESSION = 6'h04,
    SFER_ACK_WAIT = 6'h08,
    SFER_RESP_WAIT = 6'h10,
    SFER_BUF_WAIT = 6'h20
  } sfer_phase_e;
  // Received message kinds
  typedef enum logic [3:0] {
    MSG_ATTACH = 4'h0,
    MSG_ATTACH_RESP = 4'h1,
    MSG_DATAGRAM = 4'h2,
    MSG_ACK = 4'h3,
    MSG_NAK = 4'h4,
    MSG_RESPONSE = 4'h5,
    MSG_BUFFER = 4'h6,
    MSG_REQUEST = 4'h7,
    MSG_INVALID = 4'hF
  } sfer_msg_e;
endpackage : sfer_pkg

// >>> sfer_timer.sv
// Interval down-counter that pulses when a loaded interval runs out
`timescale 1ns/1ps
`default_nettype none
module sfer_timer (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Control
  input wire logic tick,
  input wire logic start,
  input wire logic stop,
  input wire logic [sfer_pkg::TIMER_W-1:0] interval,
  // Result
  output logic expired
);
  import sfer_pkg::*;
  logic [TIMER_W-1:0] count;
  logic running;

  // Load on start, count ticks, pulse once at zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (start) begin
        count <= interval;
        running <= (interval != '0);
      end else if (stop) begin
        running <= 1'b0;
      end else if (running && tick) begin
        if (count <= 1) begin
          running <= 1'b0;
          expired <= 1'b1;
        end else begin
          count <= count - 1'b1;
        end
      end
    end
  end
endmodule : sfer_timer
`default_nettype wire

// >>> sfer_reporter.sv
// Fatal error detector and minor status reporter for the serial link protocol
// Summary of operation
// - Codes 32 to 118 drop the session
// - Slave inactivity timeout reports 20h
// - Attach line errors report 21h, 22h, 23h
// - Attach type or length faults report 24h-26h
// - Slave second break awaiting attach reports 27h
// - Retransmit on NAK twice, then 28h
// - NAK received message twice, then 29h
// - Non-acknowledge while awaiting acknowledge reports 2Ah
// - Unexpected message in state reports 2Bh
// - Bad next-message-length reports 2Ch
// - No acknowledge in interval reports 2Dh
// - Master response timeout reports 2Eh
// - Buffer message timeout reports 2Fh
// - Transmit blocked reports 30h
// - Slave service handler silence reports 31h
// - Command request time limit reports 32h
// - Break aborts transfer, reports 33h
// - Bad piggyback status reports 35h
// - Slave identifier check, else 36h
// - Master response length mismatch reports 37h
// - Fast response code must equal request plus 80h
// - Fast response over 1000 bytes discarded, 39h
`timescale 1ns/1ps
`default_nettype none
module sfer_reporter (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Configuration
  input wire logic is_master,
  input wire logic [sfer_pkg::TIMER_W-1:0] inactivity_interval,
  input wire logic [sfer_pkg::TIMER_W-1:0] acknowledge_interval,
  input wire logic [sfer_pkg::TIMER_W-1:0] response_interval,
  input wire logic [sfer_pkg::TIMER_W-1:0] buffer_interval,
  input wire logic [sfer_pkg::TIMER_W-1:0] request_interval,
  input wire logic [sfer_pkg::TIMER_W-1:0] output_interval,
  // Command request side
  input wire logic command_request_start,
  input wire logic command_request_attach,
  input wire logic command_request_done,
  input wire logic [63:0] slave_id,
  input wire logic piggyback_bad,
  input wire logic [7:0] request_code,
  input wire logic [15:0] expected_length,
  // Received message events
  input wire logic rx_valid,
  input wire logic [3:0] rx_kind,
  input wire logic rx_fast,
  input wire logic rx_parity_err,
  input wire logic rx_bcc_err,
  input wire logic rx_frame_err,
  input wire logic rx_len_bad,
  input wire logic [7:0] rx_resp_code,
  input wire logic [15:0] rx_data_length,
  input wire logic rx_break,
  // Transmit side
  input wire logic tx_request,
  input wire logic tx_done,
  input wire logic sent_message,
  // Service request handler
  input wire logic service_pending,
  input wire logic service_reply,
  // Actions and status
  output logic tx_retransmit,
  output logic tx_nak,
  output logic rx_discard,
  output logic abort,
  output logic session_up,
  output logic [7:0] error_code,
  output logic error_fatal,
  output logic command_request_complete
);
  import sfer_pkg::*;

  // Identifier check: 0-7 ASCII bytes of 20h-7Fh then null, rest zero; all zero is legal
  function automatic logic id_ok(input logic [63:0] id);
    logic seen_null;
    logic ok;
    seen_null = 1'b0;
    ok = 1'b1;
    for (int i = 0; i < ID_BYTES; i++) begin
      if (id[i*8 +: 8] == 8'h00) begin
        seen_null = 1'b1;
      end else if (seen_null || id[i*8+7] || id[i*8 +: 8] < 8'h20) begin
        ok = 1'b0;
      end
    end
    return ok && seen_null;
  endfunction : id_ok

  // Fatal range test
  function automatic logic is_fatal(input logic [7:0] code);
    return (code >= FATAL_LO) && (code <= FATAL_HI);
  endfunction : is_fatal

  sfer_phase_e phase;
  sfer_phase_e next_phase;
  logic [7:0] next_code;
  logic [1:0] tx_retries;
  logic [1:0] rx_naks;
  logic [$clog2(TICK_CYCLES)-1:0] div;
  logic tick;
  logic break_seen;
  logic busy;
  logic [5:0] expired;
  logic [5:0] t_start;
  logic [5:0] t_stop;
  logic [TIMER_W-1:0] t_interval [6];
  logic awaiting_attach;
  logic line_err;

  // One-millisecond tick divider
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div <= '0;
    end else if (div == $clog2(TICK_CYCLES)'(TICK_CYCLES - 1)) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end
  assign tick = (div == $clog2(TICK_CYCLES)'(TICK_CYCLES - 1));

  assign awaiting_attach = (phase == SFER_ATTACH);
  assign line_err = rx_parity_err | rx_bcc_err | rx_frame_err;

  // Timer set: 0 inactivity, 1 acknowledge, 2 response, 3 buffer, 4 request, 5 output
  assign t_interval[0] = inactivity_interval;
  assign t_interval[1] = acknowledge_interval;
  assign t_interval[2] = response_interval;
  assign t_interval[3] = buffer_interval;
  assign t_interval[4] = request_interval;
  assign t_interval[5] = output_interval;
  // Inactivity restarts on every message while slave session open
  assign t_start[0] = !is_master && rx_valid && (phase != SFER_IDLE);
  assign t_stop[0] = (phase == SFER_IDLE) || is_master;
  assign t_start[1] = sent_message;
  assign t_stop[1] = rx_valid && (rx_kind == MSG_ACK || rx_kind == MSG_NAK);
  assign t_start[2] = is_master && rx_valid && rx_kind == MSG_ACK && phase == SFER_ACK_WAIT;
  assign t_stop[2] = rx_valid && rx_kind == MSG_RESPONSE;
  assign t_start[3] = next_phase == SFER_BUF_WAIT && phase != SFER_BUF_WAIT;
  assign t_stop[3] = rx_valid && rx_kind == MSG_BUFFER;
  assign t_start[4] = command_request_start;
  assign t_stop[4] = command_request_done || !busy;
  assign t_start[5] = tx_request;
  assign t_stop[5] = tx_done;

  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_timer
      sfer_timer u_timer (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .tick(tick),
        .start(t_start[g]),
        .stop(t_stop[g]),
        .interval(t_interval[g]),
        .expired(expired[g])
      );
    end
  endgenerate

  // Error selection and phase decision, first cause wins
  always_comb begin
    next_code = CODE_NONE;
    next_phase = phase;
    if (rx_break && awaiting_attach && break_seen && !is_master) begin
      next_code = CODE_BREAK2;
    end else if (rx_break && (phase == SFER_ACK_WAIT || phase == SFER_RESP_WAIT || phase == SFER_BUF_WAIT)) begin
      next_code = CODE_BREAK;
    end else if (command_request_start && command_request_attach && piggyback_bad) begin
      next_code = CODE_PIGGY;
    end else if (command_request_start && command_request_attach && !id_ok(slave_id)) begin
      next_code = CODE_ID;
    end else if (expired[5]) begin
      next_code = CODE_TX_TO;
    end else if (expired[4]) begin
      next_code = CODE_REQ_TO;
    end else if (expired[0]) begin
      next_code = CODE_INACT;
    end else if (!is_master && service_pending && !service_reply && expired[1]) begin
      next_code = CODE_SRP;
    end else if (expired[1]) begin
      next_code = CODE_ACK_TO;
    end else if (expired[2] && is_master) begin
      next_code = CODE_RESP_TO;
    end else if (expired[3]) begin
      next_code = CODE_BUF_TO;
    end else if (rx_valid && awaiting_attach) begin
      if (rx_parity_err) begin
        next_code = CODE_PARITY;
      end else if (rx_bcc_err) begin
        next_code = CODE_BCC;
      end else if (rx_frame_err) begin
        next_code = CODE_FRAME;
      end else if (rx_kind == MSG_INVALID) begin
        next_code = CODE_BAD_TYPE;
      end else if (rx_len_bad) begin
        next_code = CODE_ATT_LEN;
      end else if (rx_kind != MSG_ATTACH && rx_kind != MSG_ATTACH_RESP && rx_kind != MSG_DATAGRAM) begin
        next_code = CODE_UNEXP_TYPE;
      end else begin
        next_phase = SFER_SESSION;
      end
    end else if (rx_valid && line_err) begin
      if (rx_naks == MAX_RETRY) begin
        next_code = CODE_RX_NAK;
      end
    end else if (rx_valid && phase == SFER_ACK_WAIT) begin
      if (rx_kind == MSG_NAK && tx_retries == MAX_RETRY) begin
        next_code = CODE_TX_RETRY;
      end else if (rx_kind == MSG_ACK) begin
        next_phase = is_master ? SFER_RESP_WAIT : SFER_SESSION;
      end else if (rx_kind != MSG_NAK) begin
        next_code = CODE_NOT_ACK;
      end
    end else if (rx_valid && rx_len_bad) begin
      next_code = CODE_LEN;
    end else if (rx_valid && phase == SFER_RESP_WAIT) begin
      if (rx_kind != MSG_RESPONSE) begin
        next_code = CODE_SEQ;
      end else if (rx_fast && rx_data_length > MAX_FAST_DATA) begin
        next_code = CODE_BIG;
      end else if (rx_fast && rx_resp_code != request_code + RESP_OFFSET) begin
        next_code = CODE_RCODE;
      end else if (is_master && rx_data_length != expected_length) begin
        next_code = CODE_DLEN;
      end else begin
        next_phase = SFER_BUF_WAIT;
      end
    end else if (rx_valid && phase == SFER_BUF_WAIT) begin
      if (rx_kind == MSG_BUFFER) begin
        next_phase = SFER_SESSION;
      end else begin
        next_code = CODE_SEQ;
      end
    end else if (rx_valid && phase == SFER_SESSION) begin
      if (rx_kind == MSG_ACK || rx_kind == MSG_NAK || rx_kind == MSG_ATTACH_RESP) begin
        next_code = CODE_SEQ;
      end
    end else if (sent_message && phase != SFER_IDLE && phase != SFER_ATTACH) begin
      next_phase = SFER_ACK_WAIT;
    end else if (command_request_start && (command_request_attach || (rx_valid && rx_fast))) begin
      next_phase = SFER_ATTACH;
    end
    if (is_fatal(next_code)) begin
      next_phase = SFER_IDLE;
    end
  end

  // Protocol phase register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      phase <= SFER_IDLE;
    end else begin
      case (phase)
        SFER_IDLE, SFER_ATTACH, SFER_SESSION, SFER_ACK_WAIT, SFER_RESP_WAIT, SFER_BUF_WAIT: begin
          phase <= next_phase;
        end
        default: begin
          phase <= SFER_IDLE;
        end
      endcase
    end
  end

  // Break memory while waiting for attach
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      break_seen <= 1'b0;
    end else if (!awaiting_attach) begin
      break_seen <= 1'b0;
    end else if (rx_break) begin
      break_seen <= 1'b1;
    end
  end

  // Retry counters for our sends and for peer retransmissions
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_retries <= '0;
      rx_naks <= '0;
    end else begin
      if (rx_valid && phase == SFER_ACK_WAIT && rx_kind == MSG_ACK) begin
        tx_retries <= '0;
      end else if (rx_valid && phase == SFER_ACK_WAIT && rx_kind == MSG_NAK && tx_retries != MAX_RETRY) begin
        tx_retries <= tx_retries + 1'b1;
      end else if (next_phase == SFER_IDLE) begin
        tx_retries <= '0;
      end
      if (rx_valid && line_err && !awaiting_attach && rx_naks != MAX_RETRY) begin
        rx_naks <= rx_naks + 1'b1;
      end else if ((rx_valid && !line_err) || next_phase == SFER_IDLE) begin
        rx_naks <= '0;
      end
    end
  end

  // Action pulses toward the link
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_retransmit <= 1'b0;
      tx_nak <= 1'b0;
      rx_discard <= 1'b0;
      abort <= 1'b0;
    end else begin
      tx_retransmit <= rx_valid && phase == SFER_ACK_WAIT && rx_kind == MSG_NAK && next_code == CODE_NONE;
      tx_nak <= rx_valid && line_err && !awaiting_attach && next_code == CODE_NONE;
      rx_discard <= next_code == CODE_BIG;
      abort <= next_code == CODE_BREAK;
    end
  end

  // Status hold until next request; completion flag
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      error_code <= CODE_NONE;
      error_fatal <= 1'b0;
      busy <= 1'b0;
      command_request_complete <= 1'b0;
      session_up <= 1'b0;
    end else begin
      session_up <= next_phase != SFER_IDLE && next_phase != SFER_ATTACH;
      command_request_complete <= 1'b0;
      if (next_code != CODE_NONE) begin
        error_code <= next_code;
        error_fatal <= is_fatal(next_code);
        command_request_complete <= busy || command_request_start;
        busy <= 1'b0;
      end else if (command_request_start) begin
        error_code <= CODE_NONE;
        error_fatal <= 1'b0;
        busy <= 1'b1;
      end else if (busy && command_request_done) begin
        command_request_complete <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
endmodule : sfer_reporter
`default_nettype wire

// >>> sfer_peer.sv
// Remote peer model that delivers received message events and breaks
`timescale 1ns/1ps
`default_nettype none
module sfer_peer (
  // Clock
  input wire logic ref_clk,
  // Message events
  output logic rx_valid,
  output logic [3:0] rx_kind,
  output logic rx_fast,
  output logic rx_parity_err,
  output logic rx_bcc_err,
  output logic rx_frame_err,
  output logic rx_len_bad,
  output logic [7:0] rx_resp_code,
  output logic [15:0] rx_data_length,
  output logic rx_break
);
  logic [32:0] q;
  // Qualifiers of the current message
  assign {rx_kind, rx_fast, rx_parity_err, rx_bcc_err, rx_frame_err, rx_len_bad, rx_resp_code, rx_data_length} = q;
  // Idle at time zero
  initial begin
    rx_valid = 1'b0;
    rx_break = 1'b0;
    q = '0;
  end
  // One message for one cycle; qualifiers inverted once released so stale values never match
  task automatic msg(input logic [3:0] k, input logic [3:0] e, input logic f, input logic [7:0] rc,
    input logic [15:0] dl);
    @(negedge ref_clk);
    rx_valid = 1'b1;
    q = {k, f, e, rc, dl};
    @(negedge ref_clk);
    rx_valid = 1'b0;
    q = ~q;
  endtask : msg
  // One break condition
  task automatic brk;
    @(negedge ref_clk);
    rx_break = 1'b1;
    @(negedge ref_clk);
    rx_break = 1'b0;
  endtask : brk
endmodule : sfer_peer
`default_nettype wire

// >>> sfer_reporter_assertions.sv
// Concurrent checks on the fatal error reporter ports
`timescale 1ns/1ps
`default_nettype none
module sfer_reporter_assertions (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Request and receive side
  input wire logic command_request_start,
  input wire logic command_request_attach,
  input wire logic [63:0] slave_id,
  input wire logic piggyback_bad,
  input wire logic rx_valid,
  input wire logic [3:0] rx_kind,
  input wire logic rx_break,
  // Outputs
  input wire logic tx_retransmit,
  input wire logic tx_nak,
  input wire logic abort,
  input wire logic session_up,
  input wire logic [7:0] error_code,
  input wire logic error_fatal
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  logic nak_in;
  logic att_go;
  // Message and request qualifiers
  assign nak_in = rx_valid && rx_kind == 4'h4;
  assign att_go = command_request_start && command_request_attach && !rx_break;
  a_fatal_range: assert property (error_fatal == (error_code >= 8'h20 && error_code <= 8'h76))
    else $error("fatal flag disagrees with code");
  a_fatal_drop: assert property ($rose(error_fatal) |-> !session_up)
    else $error("session kept after fatal code");
  a_retry_nak: assert property (tx_retransmit |-> $past(nak_in))
    else $error("retransmit without a NAK");
  a_retry_limit: assert property ($rose(error_code == 8'h28) |-> $past(nak_in))
    else $error("retry limit code without a NAK");
  a_nak_cause: assert property (tx_nak |-> $past(rx_valid))
    else $error("NAK sent without a message");
  a_break_abort: assert property (rx_break && session_up && !command_request_start |=> abort && error_code == 8'h33)
    else $error("break did not abort");
  a_piggy_bad: assert property (att_go && piggyback_bad |=> error_code == 8'h35 && !session_up)
    else $error("bad status area not reported");
  a_id_bad: assert property (att_go && !piggyback_bad && slave_id[7:0] == 8'h01 |=> error_code == 8'h36)
    else $error("bad identifier not reported");
  a_code_hold: assert property (error_code != 8'h00 && !command_request_start |=> error_code != 8'h00)
    else $error("code lost before next request");
  a_code_clear: assert property (command_request_start && !command_request_attach && !rx_valid && !rx_break
    |=> error_code == 8'h00)
    else $error("code not cleared by request");
endmodule : sfer_reporter_assertions
bind sfer_reporter sfer_reporter_assertions sfer_reporter_assertions_i (.*);
`default_nettype wire

// >>> sfer_reporter_bench.sv
// Self-checking bench for the serial link fatal error reporter
`timescale 1ns/1ps
`default_nettype none
module sfer_reporter_bench;
  import sfer_pkg::*;
  logic ref_clk, resetn, is_master, command_request_start, command_request_attach, command_request_done;
  logic piggyback_bad, sent_message, tx_request, tx_done, service_pending, service_reply;
  logic rx_valid, rx_fast, rx_parity_err, rx_bcc_err, rx_frame_err, rx_len_bad, rx_break;
  logic tx_retransmit, tx_nak, rx_discard, abort, session_up, error_fatal, command_request_complete;
  logic [15:0] ivl, expected_length, rx_data_length, dl;
  logic [63:0] slave_id;
  logic [7:0] request_code, error_code, rx_resp_code, r;
  logic [3:0] rx_kind;
  int fail_count, n_checks, i;
  // Design and far-side peer
  sfer_reporter sfer_reporter_i (.inactivity_interval(ivl), .acknowledge_interval(ivl),
    .response_interval(ivl), .buffer_interval(ivl), .request_interval(ivl), .output_interval(ivl), .*);
  sfer_peer sfer_peer_i (.*);
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr
  // Expected code of a master response case
  function automatic logic [7:0] resp_exp(input int c);
    return (c == 1) ? 8'h38 : (c == 2) ? 8'h39 : (c == 3) ? 8'h37 : 8'h00;
  endfunction : resp_exp
  // Command request start, outputs settled on return
  task automatic req(input logic att, input logic [63:0] id, input logic pb);
    @(negedge ref_clk);
    command_request_start = 1'b1;
    command_request_attach = att;
    slave_id = id;
    piggyback_bad = pb;
    @(negedge ref_clk);
    command_request_start = 1'b0;
    @(negedge ref_clk);
  endtask : req
  task automatic rx(input logic [3:0] k, input logic [3:0] e, input logic f, input logic [7:0] rc,
    input logic [15:0] d);
    sfer_peer_i.msg(k, e, f, rc, d);
  endtask : rx
  task automatic sent;
    @(negedge ref_clk);
    sent_message = 1'b1;
    @(negedge ref_clk);
    sent_message = 1'b0;
  endtask : sent
  task automatic att(input logic [63:0] id);
    req(1'b1, id, 1'b0);
    rx(4'h0, 4'h0, 1'b0, 8'h00, 16'h0000);
    chk(session_up, 16'h0001);
  endtask : att
  // Watchdog
  initial begin
    #2000000;
    fail_count++;
    close_out();
  end
  // Main sequence
  initial begin
    {resetn, is_master, command_request_start, command_request_attach, command_request_done} = '0;
    {piggyback_bad, sent_message, tx_request, tx_done, service_pending, service_reply} = '0;
    {slave_id, request_code, expected_length, ivl} = '0;
    fail_count = 0;
    n_checks = 0;
    r = 8'h62;
    repeat (4) @(negedge ref_clk);
    chk(error_code, 16'h0000);
    resetn = 1'b1;
    // Attach line and type faults
    for (i = 0; i < 6; i++) begin
      req(1'b1, 64'h0, 1'b0);
      rx((i == 3) ? 4'hF : (i == 5) ? 4'h3 : 4'h0, (i < 3) ? (4'h8 >> i) : (i == 4) ? 4'h1 : 4'h0,
        1'b0, 8'h00, 16'h0000);
      chk(error_code, 8'h21 + i[7:0]);
      chk({session_up, error_fatal}, 16'h0001);
    end
    $display("attach fault test done");
    // Identifier and status area checks
    r = lfsr(r);
    req(1'b1, {r, 48'h0, 8'h01}, 1'b0);
    chk(error_code, 16'h0036);
    req(1'b1, 64'h0, 1'b1);
    chk(error_code, 16'h0035);
    att({48'h0, 8'h00, 8'h41 + {3'h0, r[4:0]}});
    $display("identifier test done");
    // Retry limit, then hold and clear of the code
    att(64'h0);
    sent();
    for (i = 0; i < 3; i++) begin
      rx(4'h4, 4'h0, 1'b0, 8'h00, 16'h0000);
      chk(tx_retransmit, (i < 2) ? 16'h0001 : 16'h0000);
    end
    chk(error_code, 16'h0028);
    chk(command_request_complete, 16'h0001);
    repeat (5) @(negedge ref_clk);
    chk(error_code, 16'h0028);
    req(1'b0, 64'h0, 1'b0);
    chk({error_fatal, error_code}, 16'h0000);
    $display("retry test done");
    // Received message faults in session
    for (i = 0; i < 3; i++) begin
      att(64'h0);
      if (i == 0) begin
        sent();
      end
      rx((i == 0) ? 4'h5 : (i == 1) ? 4'h3 : 4'h7, (i == 2) ? 4'h1 : 4'h0, 1'b0, 8'h00, 16'h0000);
      chk(error_code, 8'h2A + i[7:0]);
    end
    att(64'h0);
    for (i = 0; i < 3; i++) begin
      rx(4'h7, 4'h8, 1'b0, 8'h00, 16'h0000);
      chk(tx_nak, (i < 2) ? 16'h0001 : 16'h0000);
    end
    chk(error_code, 16'h0029);
    // Second break while a slave still waits for the attach, then a break that aborts in acknowledge wait
    req(1'b1, 64'h0, 1'b0);
    sfer_peer_i.brk();
    sfer_peer_i.brk();
    chk(error_code, 16'h0027);
    att(64'h0);
    sent();
    sfer_peer_i.brk();
    chk({abort, error_code}, 16'h0133);
    $display("session fault test done");
    // Master response checks
    for (i = 0; i < 4; i++) begin
      att(64'h0);
      is_master = 1'b1;
      r = lfsr(r);
      request_code = r;
      expected_length = (i == 1 || i == 3) ? 16'h03E8 - {8'h00, r} : 16'h03E8;
      dl = (i == 2) ? 16'h03E9 : (i == 3) ? expected_length + 16'h0001 : expected_length;
      sent();
      rx(4'h3, 4'h0, 1'b0, 8'h00, 16'h0000);
      rx(4'h5, 4'h0, i != 3, r + 8'h80 + {7'h00, i == 1}, dl);
      chk(error_code, resp_exp(i));
      chk(rx_discard, i == 2);
      if (i == 0) begin
        rx(4'h6, 4'h0, 1'b0, 8'h00, 16'h0000);
        rx(4'h3, 4'h0, 1'b0, 8'h00, 16'h0000);
        chk(error_code, 16'h002B);
      end
      is_master = 1'b0;
    end
    $display("response test done");
    close_out();
  end
endmodule : sfer_reporter_bench
`default_nettype wire
